// file: serial_capture_defs.vh
// Purpose: shared constants for the external serial symbol data capture block
// Assumes: included by bare name from the capture modules
// Notes:   definitions only
`ifndef SERIAL_CAPTURE_DEFS_VH
`define SERIAL_CAPTURE_DEFS_VH

// reference clock and the fastest permitted link figures
`define REF_CLK_MHZ        40
`define LINK_MAX_CLK_MHZ   50
`define LINK_MAX_RATE_MBPS 50

// depth of the pin synchroniser
`define SYNC_STAGES        2

// lane positions inside the synchronised link bus
`define LANE_DATA          0
`define LANE_BCLK          1
`define LANE_MARK          2
`define LANE_COUNT         3

// operating modes of the boundary input
`define MODE_COMBINED      1'h0
`define MODE_SYMCLK        1'h1

// default symbol length in bits and its counter width
`define SYM_BITS_DEF       8
`define SYM_CNT_W_DEF      3

// level meanings of the serial data pin
`define DATA_HIGH_BIT      1'h1
`define DATA_LOW_BIT       1'h0

`endif

// file: pin_sync.v
// Purpose: two-stage synchroniser for a bundle of asynchronous pins
// Assumes: each lane is an independent level; no lane relation is kept
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_srst,
    // asynchronous levels in
    input  wire [WIDTH-1:0] i_async,
    // synchronised levels out
    output wire [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge i_clk) begin
        if (i_srst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

`default_nettype wire

// file: serial_capture.v
// Purpose: capture externally clocked serial modulation data and symbol boundaries
// Assumes: all three link pins are asynchronous to I_REF_CLK; mode input is local logic
// Notes:   link edges are found by oversampling, so the bit clock must stay well below
//          half the reference rate in practice even though the link allows more
//
// Overview of operation
// - sample data and boundary on bit clock fall
// - boundary single pulse or repeated, both accepted
// - symbol-clock mode: sample data on boundary fall
// - high level is bit 1, low is 0
// - capture data at any rate up to limit
// - sampling works at any clock up to limit
// - boundary input selectable: marker or symbol clock
`timescale 1ns/100ps
`default_nettype none
`include "serial_capture_defs.vh"

module serial_capture #(
    parameter SYM_BITS  = `SYM_BITS_DEF,
    parameter SYM_CNT_W = `SYM_CNT_W_DEF
) (
    // clock and reset
    input  wire                 I_REF_CLK,
    input  wire                 I_SRST,
    // configuration
    input  wire                 I_SYMCLK_MODE,
    // external link pins
    input  wire                 I_SER_DATA,
    input  wire                 I_BIT_CLK,
    input  wire                 I_SYM_MARK,
    // captured bit stream
    output reg                  O_BIT_VALID,
    output reg                  O_BIT_DATA,
    output reg                  O_SYM_FIRST,
    output reg  [SYM_CNT_W-1:0] O_BIT_INDEX,
    // assembled symbols
    output reg                  O_SYM_VALID,
    output reg  [SYM_BITS-1:0]  O_SYM_WORD
);

    // keeps the figures visible to anyone sizing the reference clock
    localparam integer REF_MHZ      = `REF_CLK_MHZ;
    localparam integer LINK_MAX_MHZ = `LINK_MAX_CLK_MHZ;
    localparam integer LINK_MAX_MBS = `LINK_MAX_RATE_MBPS;

    localparam [SYM_CNT_W-1:0] CNT_ZERO = {SYM_CNT_W{1'b0}};
    localparam [SYM_CNT_W-1:0] CNT_ONE  = {{(SYM_CNT_W-1){1'b0}}, 1'b1};
    // cut to the counter width on purpose; SYM_CNT_W must cover SYM_BITS-1
    localparam integer         LAST_IDX = SYM_BITS - 1;
    localparam [SYM_CNT_W-1:0] CNT_LAST = LAST_IDX[SYM_CNT_W-1:0];

    // falling edge seen between the previous and current synchronised level
    function fell;
        input prev_lvl;
        input cur_lvl;
        begin
            fell = prev_lvl & ~cur_lvl;
        end
    endfunction

    // all three pins share one synchroniser, but each lane resolves on its own so their relative timing is not kept
    wire [`LANE_COUNT-1:0] link_raw;
    wire [`LANE_COUNT-1:0] link_s;

    assign link_raw[`LANE_DATA] = I_SER_DATA;
    assign link_raw[`LANE_BCLK] = I_BIT_CLK;
    assign link_raw[`LANE_MARK] = I_SYM_MARK;

    pin_sync #(
        .WIDTH (`LANE_COUNT)
    ) u_pin_sync (
        .i_clk   (I_REF_CLK),
        .i_srst  (I_SRST),
        .i_async (link_raw),
        .o_sync  (link_s)
    );

    reg                 bclk_prev_q;
    reg                 mark_prev_q;
    reg                 mode_q;
    reg [SYM_CNT_W-1:0] cnt_q;
    reg [SYM_CNT_W-1:0] cnt_d;
    reg [SYM_BITS-1:0]  word_q;
    reg [SYM_BITS-1:0]  word_d;
    reg                 have_sync_q;
    reg                 have_sync_d;

    wire data_s  = link_s[`LANE_DATA];
    wire bclk_s  = link_s[`LANE_BCLK];
    wire mark_s  = link_s[`LANE_MARK];

    // pin level maps straight onto bit value
    wire data_bit = data_s ? `DATA_HIGH_BIT : `DATA_LOW_BIT;

    wire bclk_fall = fell(bclk_prev_q, bclk_s);
    wire mark_fall = fell(mark_prev_q, mark_s);

    // the active sampling strobe depends on how the boundary input is used
    wire sample_stb = (mode_q == `MODE_SYMCLK) ? mark_fall : bclk_fall;

    // boundary is only meaningful as a marker in combined mode
    wire mark_hit = (mode_q == `MODE_COMBINED) & mark_s;

    always @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            bclk_prev_q <= 1'b0;
            mark_prev_q <= 1'b0;
            mode_q      <= `MODE_COMBINED;
        end else begin
            bclk_prev_q <= bclk_s;
            mark_prev_q <= mark_s;
            mode_q      <= I_SYMCLK_MODE;
        end
    end

    // bit position and symbol assembly
    always @* begin
        cnt_d       = cnt_q;
        word_d      = word_q;
        have_sync_d = have_sync_q;
        if (sample_stb) begin
            if (mode_q == `MODE_SYMCLK) begin
                // each boundary fall is one symbol clock; bits still counted
                word_d = {word_q[SYM_BITS-2:0], data_bit};
                cnt_d  = (cnt_q == CNT_LAST) ? CNT_ZERO : cnt_q + CNT_ONE;
            end else if (mark_hit) begin
                // marker restarts the symbol; new word starts with this bit
                word_d      = {{(SYM_BITS-1){1'b0}}, data_bit};
                cnt_d       = CNT_ZERO;
                have_sync_d = 1'b1;
            end else begin
                // free wrap lets a single marker pulse frame every symbol
                word_d = {word_q[SYM_BITS-2:0], data_bit};
                cnt_d  = (cnt_q == CNT_LAST) ? CNT_ZERO : cnt_q + CNT_ONE;
            end
        end
    end

    always @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            cnt_q       <= CNT_ZERO;
            word_q      <= {SYM_BITS{1'b0}};
            have_sync_q <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            word_q      <= word_d;
            have_sync_q <= mode_q == `MODE_SYMCLK ? 1'b1 : have_sync_d;
        end
    end

    // output stage: every output is a flip-flop
    always @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            O_BIT_VALID <= 1'b0;
            O_BIT_DATA  <= 1'b0;
            O_SYM_FIRST <= 1'b0;
            O_BIT_INDEX <= CNT_ZERO;
            O_SYM_VALID <= 1'b0;
            O_SYM_WORD  <= {SYM_BITS{1'b0}};
        end else begin
            O_BIT_VALID <= sample_stb;
            O_SYM_VALID <= 1'b0;
            if (sample_stb) begin
                O_BIT_DATA  <= data_bit;
                O_SYM_FIRST <= (cnt_d == CNT_ZERO);
                O_BIT_INDEX <= cnt_d;
                // a symbol is only reported once framing is known
                if ((cnt_d == CNT_LAST) && have_sync_d) begin
                    O_SYM_VALID <= 1'b1;
                    O_SYM_WORD  <= word_d;
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: serial_capture_props.sv
// Purpose: concurrent checks on the capture block ports
// Assumes: link pins change slowly against the reference clock
// Notes:   bound into every serial_capture
`timescale 1ns/100ps
`default_nettype none
module serial_capture_props #(
    parameter SYM_BITS  = 8,
    parameter SYM_CNT_W = 3
) (
    input wire logic                 I_REF_CLK,
    input wire logic                 I_SRST,
    input wire logic                 I_SYMCLK_MODE,
    input wire logic                 I_SER_DATA,
    input wire logic                 I_BIT_CLK,
    input wire logic                 I_SYM_MARK,
    input wire logic                 O_BIT_VALID,
    input wire logic                 O_BIT_DATA,
    input wire logic                 O_SYM_FIRST,
    input wire logic [SYM_CNT_W-1:0] O_BIT_INDEX,
    input wire logic                 O_SYM_VALID,
    input wire logic [SYM_BITS-1:0]  O_SYM_WORD
);
    logic [SYM_CNT_W-1:0] last_q;
    logic                 seen_q;
    wire                  strobe = I_SYMCLK_MODE ? I_SYM_MARK : I_BIT_CLK;
    always @(posedge I_REF_CLK) begin
        if (I_SRST) begin
            last_q <= '0;
            seen_q <= 1'h0;
        end else if (O_BIT_VALID) begin
            last_q <= O_BIT_INDEX;
            seen_q <= 1'h1;
        end
    end
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_SRST);
    sequence s_fall;
        $fell(strobe);
    endsequence
    sequence s_bit_out;
        ##[1:3] O_BIT_VALID;
    endsequence
    chk_fall_gives_bit: assert property (s_fall |-> s_bit_out)
        else $error("no bit after strobe fall");
    chk_bit_pulse: assert property (O_BIT_VALID |=> !O_BIT_VALID [*4])
        else $error("bit pulse too long");
    chk_data_level: assert property (O_BIT_VALID |-> O_BIT_DATA == $past(I_SER_DATA, 3))
        else $error("bit level wrong");
    chk_strobe_low: assert property (O_BIT_VALID |-> !$past(strobe, 2))
        else $error("bit without strobe fall");
    chk_mark_restart: assert property (O_BIT_VALID && !I_SYMCLK_MODE && $past(I_SYM_MARK, 3)
        |-> O_SYM_FIRST && O_BIT_INDEX == 0)
        else $error("marker did not restart count");
    chk_index_step: assert property (O_BIT_VALID && seen_q
        && (I_SYMCLK_MODE || !$past(I_SYM_MARK, 3))
        |-> O_BIT_INDEX == SYM_CNT_W'(last_q + 1'h1))
        else $error("index did not advance");
    chk_sym_last: assert property (O_SYM_VALID |-> O_BIT_VALID && O_BIT_INDEX == SYM_BITS - 1)
        else $error("symbol report off last bit");
    chk_first_flag: assert property (O_BIT_VALID |-> O_SYM_FIRST == (O_BIT_INDEX == 0))
        else $error("first flag wrong");
endmodule
bind serial_capture serial_capture_props #(.SYM_BITS(SYM_BITS), .SYM_CNT_W(SYM_CNT_W)) props (.*);
`default_nettype wire

// file: serial_source.sv
// Purpose: external serial data source model
// Assumes: 200 ns bits, clocks idle low
// Notes:   each symbol adds a 3 ns lag so the phase drifts
`timescale 1ns/100ps
`default_nettype none
module serial_source (
    output var logic o_data,
    output var logic o_bclk,
    output var logic o_mark
);
    initial begin
        o_data = 1'h0;
        o_bclk = 1'h0;
        o_mark = 1'h0;
    end
    // sc high: the marker is the strobe and the bit clock must be ignored
    task automatic send_sym(input logic [7:0] w, input logic m, input logic sc);
        #3;
        for (int i = 7; i >= 0; i--) begin
            o_data = w[i];
            o_mark = sc | (m & i == 7);
            o_bclk = 1'h1;
            #100;
            o_bclk = 1'h0;
            if (sc)
                o_mark = 1'h0;
            #100;
        end
        o_data = !o_data;
        o_mark = 1'h0;
    endtask
endmodule
`default_nettype wire

// file: serial_capture_bench.sv
// Purpose: self-checking bench for serial_capture
// Assumes: 40 MHz reference, 200 ns link bits
// Notes:   random words with fixed corner words
`timescale 1ns/100ps
`default_nettype none
module serial_capture_bench;
    logic       clk = 1'h0;
    logic       srst = 1'h1;
    logic       mode = 1'h0;
    wire        sdat, bclk, mark, bval, bdat, sval, sfirst;
    wire  [2:0] sidx;
    wire  [7:0] sword;
    integer     err_total = 0;
    integer     compares = 0;
    integer     seed = 32'h6A1947AF;
    // expected bit entries: {first flag, index, bit}
    logic [4:0] eb[$];
    logic [7:0] ew[$];
    always #12.5 clk = !clk;
    serial_source src (.o_data(sdat), .o_bclk(bclk), .o_mark(mark));
    serial_capture dut (.I_REF_CLK(clk), .I_SRST(srst), .I_SYMCLK_MODE(mode),
        .I_SER_DATA(sdat), .I_BIT_CLK(bclk), .I_SYM_MARK(mark), .O_BIT_VALID(bval),
        .O_BIT_DATA(bdat), .O_SYM_FIRST(sfirst), .O_BIT_INDEX(sidx), .O_SYM_VALID(sval),
        .O_SYM_WORD(sword));
    function automatic logic bit_of(input logic [7:0] v, input integer k);
        return v[7 - k];
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task wrap_up;
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task frame(input logic [7:0] v, input logic m, input logic sc);
        for (int k = 0; k < 8; k++)
            eb.push_back({k == 0, 3'(k), bit_of(v, k)});
        ew.push_back(v);
        src.send_sym(v, m, sc);
    endtask
    always @(posedge clk) begin
        // an empty queue would hand back zero and hide a spurious strobe
        if (bval === 1'h1) begin
            chk({7'h00, eb.size() != 0}, 8'h01, "bit due");
            if (eb.size() != 0)
                chk({3'h0, sfirst, sidx, bdat}, {3'h0, eb.pop_front()}, "bit");
        end
        if (sval === 1'h1) begin
            chk({7'h00, ew.size() != 0}, 8'h01, "word due");
            if (ew.size() != 0)
                chk(sword, ew.pop_front(), "word");
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'h0;
        repeat (4) @(posedge clk);
        frame(8'hA5, 1'h1, 1'h0);
        repeat (3) frame(8'($random(seed)), 1'h0, 1'h0);
        frame(8'h00, 1'h1, 1'h0);
        frame(8'hFF, 1'h1, 1'h0);
        repeat (10) @(posedge clk);
        mode <= 1'h1;
        repeat (4) @(posedge clk);
        repeat (3) frame(8'($random(seed)), 1'h0, 1'h1);
        repeat (10) @(posedge clk);
        chk(8'(eb.size() + ew.size()), 8'h00, "left");
        wrap_up;
    end
    initial begin
        #60000;
        err_total++;
        wrap_up;
    end
endmodule
`default_nettype wire
